// ===== logic/pif_flags.sv
`timescale 1ns/100ps
module pif_flags import pif_pkg::*; #(
    parameter int AW = 16
) (
    input  wire logic          MCLK,          // system clock, 40 MHz
    input  wire logic          RESETN,        // synchronous reset, active low
    input  wire logic          CLK_EN,        // freezes all state while low
    input  wire logic          PSEL,          // apb select
    input  wire logic          PENABLE,       // apb access phase
    input  wire logic          PWRITE,        // apb direction
    input  wire logic [AW-1:0] PADDR,         // apb byte address
    input  wire logic [31:0]   PWDATA,        // apb write data
    output logic [31:0]        PRDATA,        // apb read data
    output logic               PREADY,        // apb ready
    output logic               PSLVERR,       // unmapped address
    output logic               IRQ,           // level interrupt
    input  wire logic          ZERO_CROSS_OUT, // zero-cross detector output level
    input  wire logic [1:0]    CMP_OUT,       // comparator output levels
    input  wire logic [1:0]    RX_FULL,       // receive buffer full per transceiver
    input  wire logic [1:0]    TX_EMPTY,      // transmit buffer empty per transceiver
    input  wire logic [1:0]    BCL_EVT,       // bus collision pulses
    input  wire logic [1:0]    SSP_DONE,      // sync port done pulses
    input  wire logic [2:0]    TMR_MATCH,     // timers 2, 4, 6 period match
    input  wire logic [2:0]    TMR_OVF,       // timers 1, 3, 5 overflow
    input  wire logic [2:0]    TMR_GATE,      // timers 1, 3, 5 gate events
    input  wire logic [1:0]    CCP_EVT,       // capture or compare event pulses
    input  wire logic [3:0]    CCP_MODE,      // two bits of mode per unit
    input  wire logic          SCAN_EVT,      // scanner event
    input  wire logic          CRC_EVT,       // checksum event
    input  wire logic          NVM_EVT,       // nonvolatile memory event
    input  wire logic          CWG_EVT        // waveform generator event
);

    logic [7:0]  flag_q [NUM_FLAG_REGS];
    logic [7:0]  flag_d [NUM_FLAG_REGS];
    logic [7:0]  set_v  [NUM_FLAG_REGS];
    logic [7:0]  rw_v   [NUM_FLAG_REGS];
    logic [5:0]  new_evt;
    logic [5:0]  stat_q;
    logic [5:0]  stat_d;
    logic [5:0]  mask_q;
    logic [5:0]  mask_d;
    logic        zero_cross_q;
    logic [1:0]  cmp_q;
    logic        primed_q;
    logic        pready_q;
    logic        pslverr_q;
    logic        irq_q;
    logic [31:0] prdata_q;
    logic [31:0] rd_mux;
    logic [2:0]  slot;
    logic        hit;
    logic        setup;
    logic        acc;
    logic        wr_en;
    logic        zero_cross_chg;
    logic [1:0]  cmp_chg;
    logic [1:0]  ccp_set;
    logic [IDX_W-1:0] idx;

    // bus phases; a write lands only at the edge where ready is seen
    assign setup = CLK_EN & PSEL & ~PENABLE;
    assign acc   = CLK_EN & PSEL & PENABLE & pready_q;
    assign wr_en = acc & PWRITE & hit;
    assign idx   = PADDR[IDX_W+1:2];

    always_comb begin
        hit  = 1'b1;
        slot = SLOT_ANALOG;
        if (PADDR[1:0] != 2'b00 || PADDR[AW-1:IDX_W+2] != '0) begin
            hit = 1'b0;
        end else if (idx == IDX_ANALOG) begin
            slot = SLOT_ANALOG;
        end else if (idx == IDX_SERIAL) begin
            slot = SLOT_SERIAL;
        end else if (idx == IDX_TIMER) begin
            slot = SLOT_TIMER;
        end else if (idx == IDX_GATE) begin
            slot = SLOT_GATE;
        end else if (idx == IDX_CAPCOMP) begin
            slot = SLOT_CAPCOMP;
        end else if (idx == IDX_MISC) begin
            slot = SLOT_MISC;
        end else if (idx == IDX_IRQ_STAT) begin
            slot = SLOT_STAT;
        end else if (idx == IDX_IRQ_MASK) begin
            slot = SLOT_MASK;
        end else begin
            hit = 1'b0;
        end
    end

    // level changes; the first sample after reset only primes the history
    // zero-cross change
    assign zero_cross_chg = primed_q & (ZERO_CROSS_OUT ^ zero_cross_q);
    assign cmp_chg = {2{primed_q}} & (CMP_OUT ^ cmp_q);

    // set in any mode but pulse-width, so capture, compare and the unused encoding 3
    assign ccp_set[0] = CCP_EVT[0] & (CCP_MODE[1:0] != PIF_CCP_PWM);
    assign ccp_set[1] = CCP_EVT[1] & (CCP_MODE[3:2] != PIF_CCP_PWM);

    assign set_v[0] = {1'b0, zero_cross_chg, 4'h0, cmp_chg};
    assign set_v[1] = {RX_FULL[1], TX_EMPTY[1], RX_FULL[0], TX_EMPTY[0],
                       BCL_EVT[1], SSP_DONE[1], BCL_EVT[0], SSP_DONE[0]};
    assign set_v[2] = {2'b00, TMR_MATCH[2], TMR_OVF[2], TMR_MATCH[1], TMR_OVF[1],
                       TMR_MATCH[0], TMR_OVF[0]};
    assign set_v[3] = {5'h00, TMR_GATE};
    assign set_v[4] = {6'h00, ccp_set};
    assign set_v[5] = {SCAN_EVT, CRC_EVT, NVM_EVT, 4'h0, CWG_EVT};

    assign rw_v[0] = RW_ANALOG;
    assign rw_v[1] = RW_SERIAL;
    assign rw_v[2] = RW_TIMER;
    assign rw_v[3] = RW_GATE;
    assign rw_v[4] = RW_CAPCOMP;
    assign rw_v[5] = RW_MISC;

    // one flag register per flag slot 0 to 5; the read-only serial bits simply track
    // their level input because they are outside the hold mask
    genvar r;
    generate
        for (r = 0; r < NUM_FLAG_REGS; r++) begin : g_flag
            logic wr_here;
            assign wr_here = wr_en & (slot == 3'(r));
            // store writable bits, set wins over a clearing write
            assign flag_d[r] = set_v[r] | ((wr_here ? PWDATA[7:0] : flag_q[r]) & rw_v[r]);
            assign new_evt[r] = |(flag_d[r] & ~flag_q[r]);
            always_ff @(posedge MCLK) begin
                if (!RESETN) begin
                    flag_q[r] <= FLAG_RESET;
                end else if (CLK_EN) begin
                    flag_q[r] <= flag_d[r];
                end
            end
        end
    endgenerate

    // interrupt status is write-one-to-clear, a new event wins the race
    assign stat_d = new_evt | (stat_q & ~((wr_en && slot == SLOT_STAT) ? PWDATA[5:0] : 6'h00));
    assign mask_d = (wr_en && slot == SLOT_MASK) ? PWDATA[5:0] : mask_q;

    // read mux, sampled in the setup cycle so data is a flop output
    always_comb begin
        rd_mux = RDATA_RESET;
        if (slot == SLOT_STAT) begin
            rd_mux[5:0] = stat_q;
        end else if (slot == SLOT_MASK) begin
            rd_mux[5:0] = mask_q;
        end else begin
            rd_mux[7:0] = flag_q[slot];
        end
        if (!hit) begin
            rd_mux = RDATA_RESET;
        end
    end

    // edge history and interrupt state
    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            zero_cross_q <= 1'b0;
            cmp_q    <= 2'b00;
            primed_q <= 1'b0;
            stat_q   <= STAT_RESET;
            mask_q   <= MASK_RESET;
            irq_q    <= 1'b0;
        end else if (CLK_EN) begin
            zero_cross_q <= ZERO_CROSS_OUT;
            cmp_q    <= CMP_OUT;
            primed_q <= 1'b1;
            stat_q   <= stat_d;
            mask_q   <= mask_d;
            irq_q    <= |(stat_d & mask_d);
        end
    end

    // one wait-free access: ready rises the cycle after setup
    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= RDATA_RESET;
        end else if (CLK_EN) begin
            pready_q  <= setup;
            pslverr_q <= setup & ~hit;
            if (setup) begin
                prdata_q <= PWRITE ? RDATA_RESET : rd_mux;
            end
        end
    end

    assign PRDATA  = prdata_q;
    assign PREADY  = pready_q;
    assign PSLVERR = pslverr_q;
    assign IRQ     = irq_q;

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESETN);

    AST_ZERO_CROSS_SET: assert property (CLK_EN && zero_cross_chg |=> flag_q[0][BIT_ZERO_CROSS])
        else $error("zero-cross change did not set flag");
    AST_CMP_SET: assert property (CLK_EN && cmp_chg[1] |=> flag_q[0][1])
        else $error("comparator change did not set flag");
    AST_RX_TRACK: assert property (CLK_EN |=> flag_q[1][7] == $past(RX_FULL[1]))
        else $error("receive flag does not follow buffer level");
    AST_TX_TRACK: assert property (CLK_EN |=> flag_q[1][4] == $past(TX_EMPTY[0]))
        else $error("transmit flag does not follow buffer level");
    AST_BCL_SET: assert property (CLK_EN && BCL_EVT[1] |=> flag_q[1][3])
        else $error("collision did not set flag");
    AST_MATCH_SET: assert property (CLK_EN && TMR_MATCH[2] |=> flag_q[2][5])
        else $error("timer6 match did not set flag");
    AST_PWM_HOLD: assert property (CLK_EN && CCP_MODE[1:0] == PIF_CCP_PWM && !wr_en
        |=> flag_q[4][0] == $past(flag_q[4][0]))
        else $error("pulse-width mode changed the flag");
    AST_RO_ZERO: assert property (PREADY && !PWRITE && PSEL && idx == IDX_GATE && hit
        |-> PRDATA[31:3] == 29'h0)
        else $error("unimplemented gate bits read nonzero");
    AST_IRQ_LVL: assert property (CLK_EN && |(stat_d & mask_d) |=> IRQ)
        else $error("unmasked status did not raise interrupt");
    AST_READY: assert property (setup |=> PREADY ##1 !PREADY)
        else $error("ready not one cycle after setup");

    // first receive flag tracks its level
    AST_RX0_TRACK: assert property (CLK_EN |=> flag_q[1][5] == $past(RX_FULL[0]))
        else $error("receive flag 0 does not follow buffer level");

    // second transmit flag tracks its level
    AST_TX1_TRACK: assert property (CLK_EN |=> flag_q[1][6] == $past(TX_EMPTY[1]))
        else $error("transmit flag 1 does not follow buffer level");

    AST_BCL0_SET: assert property (CLK_EN && BCL_EVT[0] |=> flag_q[1][1])
        else $error("collision 0 did not set flag");

    AST_SSP0_SET: assert property (CLK_EN && SSP_DONE[0] |=> flag_q[1][0])
        else $error("sync port 0 done did not set flag");
    AST_SSP1_SET: assert property (CLK_EN && SSP_DONE[1] |=> flag_q[1][2])
        else $error("sync port 1 done did not set flag");

    AST_OVF_SET: assert property (CLK_EN && TMR_OVF[0] |=> flag_q[2][0])
        else $error("timer1 overflow did not set flag");

    AST_GATE_SET: assert property (CLK_EN && TMR_GATE[2] |=> flag_q[3][2])
        else $error("timer5 gate did not set flag");

    AST_CAPT_SET: assert property (CLK_EN && CCP_EVT[0] && CCP_MODE[1:0] == PIF_CCP_CAPTURE
        |=> flag_q[4][0])
        else $error("capture did not set flag");

    // compare match sets the unit flag
    AST_CMPR_SET: assert property (CLK_EN && CCP_EVT[1] && CCP_MODE[3:2] == PIF_CCP_COMPARE
        |=> flag_q[4][1])
        else $error("compare match did not set flag");

    AST_SCAN_SET: assert property (CLK_EN && SCAN_EVT |=> flag_q[5][BIT_SCAN])
        else $error("scanner event did not set flag");

    AST_CRC_SET: assert property (CLK_EN && CRC_EVT |=> flag_q[5][BIT_CRC])
        else $error("checksum event did not set flag");
    AST_NVM_SET: assert property (CLK_EN && NVM_EVT |=> flag_q[5][BIT_NVM])
        else $error("nonvolatile event did not set flag");
    AST_CWG_SET: assert property (CLK_EN && CWG_EVT |=> flag_q[5][BIT_CWG])
        else $error("waveform event did not set flag");

    // unmapped word answers with error and zero data
    AST_SLVERR: assert property (setup && !hit |=> PSLVERR && PRDATA == 32'h0000_0000)
        else $error("unmapped access not refused");

    // a write with no event stores the writable bits only
    AST_WR_STORE: assert property (wr_en && slot == SLOT_TIMER && set_v[2] == 8'h00
        |=> flag_q[2] == ($past(PWDATA[7:0]) & RW_TIMER))
        else $error("timer flag write not stored");

    // a new flag always reaches the status bit
    AST_STAT_SET: assert property (CLK_EN && new_evt[2] |=> stat_q[2])
        else $error("new timer flag did not set status");

    // nothing is taken while the clock enable is low
    AST_FREEZE: assert property (!CLK_EN |=> flag_q[2] == $past(flag_q[2]) && stat_q == $past(stat_q))
        else $error("state moved while clock enable low");

endmodule

// ===== pkg/pif_pkg.sv
// What this block does
// - zero-cross flag sets on every detector output change, held until software clears
// - two comparator flags at bits 0 and 1 set on output change
// - read-only receive flags at bits 5 and 7 follow receive buffer full
// - read-only transmit flags at bits 4 and 6 follow transmit buffer empty
// - bus collision flags at bits 1 and 3 set on collision, software clears
// - sync port flags at bits 0 and 2 set on transfer done, software clears
// - period match flags at bits 5, 3, 1 set on timer match
// - overflow flags at bits 4, 2, 0 set on timer overflow
// - gate flags at bits 2, 1, 0 set on each gate event
// - in capture mode a capture/compare flag sets on a capture
// - in compare mode a capture/compare flag sets on a match
// - scanner flag at bit 7 of the last register sets on scanner event
// - flag registers sit at consecutive indices 0xECC to 0xED1
// - checksum, nonvolatile and waveform flags at bits 6, 5, 0
// - flags set regardless of the interrupt mask so software can poll
package pif_pkg;

    localparam int           NUM_FLAG_REGS = 6;
    localparam int           IDX_W         = 12;
    // register indices; byte address is four times the index
    localparam logic [11:0]  IDX_ANALOG    = 12'h0ECC;
    localparam logic [11:0]  IDX_SERIAL    = 12'h0ECD;
    localparam logic [11:0]  IDX_TIMER     = 12'h0ECE;
    localparam logic [11:0]  IDX_GATE      = 12'h0ECF;
    localparam logic [11:0]  IDX_CAPCOMP   = 12'h0ED0;
    localparam logic [11:0]  IDX_MISC      = 12'h0ED1;
    localparam logic [11:0]  IDX_IRQ_STAT  = 12'h0ED2;
    localparam logic [11:0]  IDX_IRQ_MASK  = 12'h0ED3;
    // slot numbers of the flag, status and mask registers inside the block
    localparam logic [2:0]   SLOT_ANALOG   = 3'h0;
    localparam logic [2:0]   SLOT_SERIAL   = 3'h1;
    localparam logic [2:0]   SLOT_TIMER    = 3'h2;
    localparam logic [2:0]   SLOT_GATE     = 3'h3;
    localparam logic [2:0]   SLOT_CAPCOMP  = 3'h4;
    localparam logic [2:0]   SLOT_MISC     = 3'h5;
    localparam logic [2:0]   SLOT_STAT     = 3'h6;
    localparam logic [2:0]   SLOT_MASK     = 3'h7;
    // software-writable bits of each flag register
    localparam logic [7:0]   RW_ANALOG     = 8'h43;
    localparam logic [7:0]   RW_SERIAL     = 8'h0F;
    localparam logic [7:0]   RW_TIMER      = 8'h3F;
    localparam logic [7:0]   RW_GATE       = 8'h07;
    localparam logic [7:0]   RW_CAPCOMP    = 8'h03;
    localparam logic [7:0]   RW_MISC       = 8'hE1;
    localparam logic [7:0]   FLAG_RESET    = 8'h00;
    localparam logic [5:0]   STAT_RESET    = 6'h00;
    localparam logic [5:0]   MASK_RESET    = 6'h00;
    localparam logic [31:0]  RDATA_RESET   = 32'h0000_0000;
    // bit positions
    localparam int           BIT_ZERO_CROSS = 6;
    localparam int           BIT_SCAN      = 7;
    localparam int           BIT_CRC       = 6;
    localparam int           BIT_NVM       = 5;
    localparam int           BIT_CWG       = 0;

    typedef enum logic [1:0] {
        PIF_CCP_CAPTURE,
        PIF_CCP_COMPARE,
        PIF_CCP_PWM
    } pif_ccp_mode_t;

endpackage

// ===== tb/pif_periph.sv
`timescale 1ns/100ps
// stand-in for the peripherals around the flag bank
module pif_periph (
    input  wire logic        clk,     // system clock
    input  wire logic        rst_n,   // synchronous reset, active low
    input  wire logic [21:0] fire,    // one-hot event request from the bench
    input  wire logic [3:0]  buf_lvl, // rx full [1:0], tx empty [3:2]
    output logic             zero_cross, // zero-cross detector output
    output logic [1:0]       cmp,     // comparator outputs
    output logic [3:0]       lvl,     // buffer levels
    output logic [18:0]      pul      // one-cycle event pulses
);
    // outputs move just after an edge, as real peripheral flops do
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            zero_cross <= 1'b0;
            cmp <= 2'b00;
        end else begin
            zero_cross <= zero_cross ^ fire[0];
            cmp <= cmp ^ fire[2:1];
        end
        lvl <= buf_lvl;
        pul <= fire[21:3];
    end
endmodule

// ===== tb/tb.sv
`timescale 1ns/100ps
module tb;
    import pif_pkg::*;
    logic        MCLK = 1'b0;
    logic        RESETN = 1'b0;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [15:0] padr = 16'h0000;
    logic [31:0] pwd = 32'h0000_0000;
    logic [21:0] fire = 22'h0;
    logic [3:0]  bufl = 4'h0;
    logic [3:0]  ccpm = 4'h4;
    logic [31:0] prd, rd_s, r;
    logic        prdy, slv, irq, rdy_s, slv_s, zero_cross;
    logic        cen = 1'b1;
    logic [1:0]  cmp;
    logic [3:0]  lvl;
    logic [18:0] pul;
    logic [32:0] expq[$];
    int          n_errors = 0;
    int          n_compared = 0;
    logic [31:0] seed = 32'h0001_34A5;
    logic [11:0] ix [22] = '{12'h0ECC, 12'h0ECC, 12'h0ECC, 12'h0ECD, 12'h0ECD, 12'h0ECD, 12'h0ECD, 12'h0ECE,
        12'h0ECE, 12'h0ECE, 12'h0ECE, 12'h0ECE, 12'h0ECE, 12'h0ECF, 12'h0ECF, 12'h0ECF, 12'h0ED0, 12'h0ED0,
        12'h0ED1, 12'h0ED1, 12'h0ED1, 12'h0ED1};
    logic [7:0]  mk [22] = '{8'h40, 8'h01, 8'h02, 8'h02, 8'h08, 8'h01, 8'h04, 8'h02, 8'h08, 8'h20, 8'h01,
        8'h04, 8'h10, 8'h01, 8'h02, 8'h04, 8'h01, 8'h02, 8'h80, 8'h40, 8'h20, 8'h01};
    logic [7:0]  rwm [6] = '{RW_ANALOG, RW_SERIAL, RW_TIMER, RW_GATE, RW_CAPCOMP, RW_MISC};

    always #12.5 MCLK = ~MCLK;

    pif_periph prt (.clk(MCLK), .rst_n(RESETN), .fire(fire), .buf_lvl(bufl), .zero_cross(zero_cross), .cmp(cmp),
        .lvl(lvl), .pul(pul));
    pif_flags dut (.MCLK(MCLK), .RESETN(RESETN), .CLK_EN(cen), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(padr), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(slv), .IRQ(irq),
        .ZERO_CROSS_OUT(zero_cross),
        .CMP_OUT(cmp), .RX_FULL(lvl[1:0]), .TX_EMPTY(lvl[3:2]), .BCL_EVT(pul[1:0]), .SSP_DONE(pul[3:2]),
        .TMR_MATCH(pul[6:4]), .TMR_OVF(pul[9:7]), .TMR_GATE(pul[12:10]), .CCP_EVT(pul[14:13]),
        .CCP_MODE(ccpm), .SCAN_EVT(pul[15]), .CRC_EVT(pul[16]), .NVM_EVT(pul[17]), .CWG_EVT(pul[18]));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input logic [32:0] g, input logic [32:0] e);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    // apb master; a read notes {slverr, data} for the monitor
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
        @(posedge MCLK);
        psel <= 1'b1;
        pwr <= w;
        padr <= {2'b00, a, 2'b00};
        pwd <= d;
        if (!w) expq.push_back(e);
        @(posedge MCLK);
        pen <= 1'b1;
        do @(posedge MCLK); while (rdy_s !== 1'b1);
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic irq_is(input logic e);
        @(negedge MCLK);
        chk({32'h0, irq}, {32'h0, e});
    endtask

    task automatic pulse(input int i);
        fire <= 22'h1 << i;
        @(posedge MCLK);
        fire <= 22'h0;
        // let an edge pass so a following pulse never reassigns fire in this step
        @(posedge MCLK);
    endtask

    task automatic conclude();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // outputs sampled mid-cycle so the edge processes never race them
    always @(negedge MCLK) begin
        rdy_s = prdy;
        slv_s = slv;
        rd_s = prd;
    end

    // monitor takes the oldest note at each completed read
    always @(posedge MCLK) begin
        if (psel && pen && rdy_s && !pwr) chk({slv_s, rd_s}, expq.pop_front());
    end

    initial begin
        repeat (16) @(posedge MCLK);
        RESETN <= 1'b1;
        // register map, all reset to zero
        for (int i = 0; i < 8; i++) xfer(1'b0, 12'h0ECC + 12'(i), 32'h0, 33'h0);
        xfer(1'b0, 12'h0ED4, 32'h0, {1'b1, 32'h0});
        // every event sets its flag with all interrupt mask bits clear
        for (int i = 0; i < 22; i++) begin
            pulse(i);
            xfer(1'b0, ix[i], 32'h0, {25'h0, mk[i]});
            xfer(1'b1, ix[i], 32'h0, 33'h0);
        end
        ccpm <= 4'hA;
        pulse(16);
        pulse(17);
        xfer(1'b0, 12'h0ED0, 32'h0, 33'h0);
        // buffer levels show in read-only bits, writes reach only rw bits
        r = xs();
        bufl <= r[3:0];
        xfer(1'b1, 12'h0ECD, 32'hFF, 33'h0);
        xfer(1'b0, 12'h0ECD, 32'h0, {25'h0, r[1], r[3], r[0], r[2], 4'hF});
        bufl <= 4'h0;
        xfer(1'b1, 12'h0ECD, 32'h0, 33'h0);
        xfer(1'b0, 12'h0ECD, 32'h0, 33'h0);
        // stale status cleared before the mask is opened
        xfer(1'b0, 12'h0ED2, 32'h0, 33'h3F);
        irq_is(1'b0);
        xfer(1'b1, 12'h0ED2, 32'h3F, 33'h0);
        xfer(1'b1, 12'h0ED3, 32'h3B, 33'h0);
        pulse(9);
        repeat (4) @(posedge MCLK);
        irq_is(1'b0);
        xfer(1'b1, 12'h0ED3, 32'h3F, 33'h0);
        repeat (2) @(posedge MCLK);
        irq_is(1'b1);
        xfer(1'b1, 12'h0ECE, 32'h0, 33'h0);
        xfer(1'b1, 12'h0ED2, 32'h04, 33'h0);
        repeat (2) @(posedge MCLK);
        irq_is(1'b0);
        // an event that arrives while the clock enable is low is not taken
        cen <= 1'b0;
        pulse(10);
        cen <= 1'b1;
        xfer(1'b0, 12'h0ECE, 32'h0, 33'h0);
        // random write keeps exactly the rw bits
        for (int i = 0; i < 6; i++) begin
            r = xs();
            xfer(1'b1, 12'h0ECC + 12'(i), r, 33'h0);
            xfer(1'b0, 12'h0ECC + 12'(i), 32'h0, {25'h0, r[7:0] & rwm[i]});
        end
        conclude();
    end

    // hang guard, well beyond the few hundred cycles of the run
    initial begin
        repeat (5000) @(posedge MCLK);
        n_errors++;
        conclude();
    end
endmodule
